// [verilog/radio_ctl_params.svh]
// Purpose: constants for the radio operating-state controller
// Assumes: CORE_CLK at 125 MHz
// Notes: times are in microseconds; cycle counts derive from them
`ifndef RADIO_CTL_PARAMS_SVH
`define RADIO_CTL_PARAMS_SVH
`define CLK_MHZ 125
`define CYC_US(t) ((t) * `CLK_MHZ)
`define HOST_BAUD 19200
`define T_RX_TXD_US 180
`define T_CHAR_US 590
`define T_TXD_IDLE_US 900
`define T_RXD_CTS_US 20
`define T_RXD_TX_US 960
`define T_TX_IDLE_US 960
`define T_CFG_PROMPT_US 590
`define T_CHAN_US 1100
`define T_MEM_CFG_US 30520
`define T_AIR_BYTE_US 1670
`define T_RSSI_US 4000
`define AIR_PRE_BYTES 7
`define AIR_ADDR_BYTES 2
`define AIR_CRC_BYTES 2
`define AIR_OVH_BYTES (`AIR_PRE_BYTES + `AIR_ADDR_BYTES + `AIR_CRC_BYTES)
`define BUF_BYTES 128
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define SEL_CMD 8'h00
`define SEL_PIN 8'h02
`define SEL_RESET 8'h00
`endif

// [verilog/radio_ctl_pkg.sv]
// Purpose: types shared by the radio operating-state controller
// Assumes: constants come from radio_ctl_params.svh
// Notes: state enum order gives idle the all-zero code
package radio_ctl_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HOST_RX,
    ST_AIR_TX,
    ST_AIR_RX,
    ST_HOST_TX,
    ST_CONFIG,
    ST_MEM_CONFIG,
    ST_SLEEP
  } op_state_e;

  typedef enum logic [1:0] {
    ACT_PROMPT,
    ACT_RSSI,
    ACT_NVM
  } cfg_act_e;

  typedef struct packed {
    op_state_e st;
    cfg_act_e act;
    logic [31:0] timer;
    logic busy;
    logic post;
    logic [7:0] tx_cnt;
    logic [7:0] rx_cnt;
    logic [11:0] cts_tmr;
    logic cts_n;
    logic prompt;
    logic char_send;
    logic tx_start;
    logic rssi;
    logic search;
    logic asleep;
    logic pull_en;
    logic nvm_wr;
    logic [7:0] sel;
    logic loaded;
    logic rxd_prev;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ctl_s;

endpackage

// [verilog/radio_pin_sync.sv]
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: pins are levels with no timing relation to clk
// Notes: only the second stage leaves the module
`timescale 1ns/100ps
module radio_pin_sync #(
  parameter int unsigned W = 3,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_s;

  sync_s s_q;
  sync_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.meta = pin_in;
    s_d.stable = s_q.meta;
  end

  // idle pins are high, so reset to high avoids a false wake or config
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q.meta <= RST_VAL;
      s_q.stable <= RST_VAL;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_out = s_q.stable;

endmodule

// [verilog/radio_state_ctl.sv]
// Purpose: operating-state and sleep controller of a packet radio module
// Assumes: byte-level UART and radio datapaths report events as pulses
// Notes: software reaches control and status over APB
// Function
// RL1 - hold outgoing and incoming payloads internally before passing them on
// RL2 - select 0x00: doze command with setup low enters sleep
// RL3 - command sleep: wake when setup pin goes high
// RL4 - command sleep: serial activity wakes briefly, resleeps if setup low
// RL5 - select 0x02: sleep while doze pin low, wake when high
// RL6 - pin sleep: serial input and setup pin never wake the device
// RL7 - host keeps setup high when waking by doze pin
// RL8 - pull-ups off while asleep; host drives wake pin high
// RL9 - settings kept through sleep; power-up reloads stored settings
// RL10 - setup low enters config; memory command enters memory config
// RL11 - first host character 180 us after last air byte
// RL12 - each host character takes 590 us including gap
// RL13 - idle again 900 us after last host character
// RL14 - clear-to-send active 20 us after last host character
// RL15 - air transmission starts 960 us after last host character
// RL16 - idle again 960 us after last air byte sent
// RL17 - prompt 590 us after setup pin goes low
// RL18 - channel command prompt after 1.1 ms; others immediately
// RL19 - memory programming takes 30.52 ms, prompt after terminator
// RL20 - air time is 1.67 ms per byte plus 11 overhead bytes
// RL21 - signal-strength byte 4 ms after its command
// RL22 - idle keeps searching for preamble while awaiting host data
// RL23 - setup pin is active low, high in normal use
// RL24 - host link 19200 baud, 8 data, 1 stop, no parity
// RL25 - one state at a time, latencies counted in clock cycles
`timescale 1ns/100ps
`include "radio_ctl_params.svh"
module radio_state_ctl #(
  parameter int unsigned RX_TXD_CYC = `CYC_US(`T_RX_TXD_US),
  parameter int unsigned CHAR_CYC = `CYC_US(`T_CHAR_US),
  parameter int unsigned TXD_IDLE_CYC = `CYC_US(`T_TXD_IDLE_US),
  parameter int unsigned RXD_TX_CYC = `CYC_US(`T_RXD_TX_US),
  parameter int unsigned TX_IDLE_CYC = `CYC_US(`T_TX_IDLE_US),
  parameter int unsigned CFG_PROMPT_CYC = `CYC_US(`T_CFG_PROMPT_US),
  parameter int unsigned CHAN_CYC = `CYC_US(`T_CHAN_US),
  parameter int unsigned MEM_CFG_CYC = `CYC_US(`T_MEM_CFG_US),
  parameter int unsigned AIR_BYTE_CYC = `CYC_US(`T_AIR_BYTE_US),
  parameter int unsigned RSSI_CYC = `CYC_US(`T_RSSI_US),
  parameter int unsigned BUF_BYTES = `BUF_BYTES
) (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RXD_PIN,
  input wire logic SETUP_MODE_N,
  input wire logic FLOW_REQUEST_DOZE,
  input wire logic HOST_BYTE,
  input wire logic HOST_END,
  input wire logic AIR_PREAMBLE,
  input wire logic AIR_BYTE,
  input wire logic AIR_END,
  input wire logic DOZE_CMD,
  input wire logic MEM_WRITE_CMD,
  input wire logic MEM_TERM,
  input wire logic CHAN_CMD,
  input wire logic RSSI_CMD,
  input wire logic OTHER_CMD,
  input wire logic EXIT_CMD,
  input wire logic [7:0] NVM_SLEEP_SEL,
  output logic HOST_CTS_N,
  output logic PROMPT_SEND,
  output logic HOST_CHAR_SEND,
  output logic AIR_TX_START,
  output logic RSSI_SEND,
  output logic PREAMBLE_SEARCH,
  output logic ASLEEP,
  output logic SETUP_PULLUP_EN,
  output logic DOZE_PULLUP_EN,
  output logic NVM_WRITE,
  output logic [7:0] NVM_WDATA,
  output logic [2:0] OP_STATE
);

  localparam int unsigned RXD_CTS_CYC = `CYC_US(`T_RXD_CTS_US);

  radio_ctl_pkg::ctl_s s_q;
  radio_ctl_pkg::ctl_s s_d;
  logic [2:0] pins;
  logic rxd_s;
  logic setup_s;
  logic doze_s;

  radio_pin_sync #(.W(3), .RST_VAL(3'h7)) u_sync (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .pin_in({RXD_PIN, SETUP_MODE_N, FLOW_REQUEST_DOZE}),
    .pin_out(pins)
  );

  assign rxd_s = pins[2];
  assign setup_s = pins[1];
  assign doze_s = pins[0];

  function automatic logic [31:0] air_cycles(input logic [7:0] n);
    air_cycles = 32'((32'(n) + `AIR_OVH_BYTES) * AIR_BYTE_CYC); // [RL20]
  endfunction

  function automatic radio_ctl_pkg::ctl_s arm(
    input radio_ctl_pkg::ctl_s c,
    input logic [31:0] cyc,
    input radio_ctl_pkg::cfg_act_e a
  );
    arm = c;
    arm.timer = cyc; // [RL25]
    arm.busy = 1'b1;
    arm.act = a;
  endfunction

  function automatic radio_ctl_pkg::ctl_s go_sleep(
    input radio_ctl_pkg::ctl_s c
  );
    go_sleep = c;
    go_sleep.st = radio_ctl_pkg::ST_SLEEP;
    go_sleep.asleep = 1'b1;
    go_sleep.pull_en = 1'b0; // [RL8]
  endfunction

  function automatic radio_ctl_pkg::ctl_s wake(
    input radio_ctl_pkg::ctl_s c,
    input logic to_cfg
  );
    wake = c;
    wake.asleep = 1'b0;
    wake.pull_en = 1'b1;
    wake.st = radio_ctl_pkg::ST_IDLE;
    if (to_cfg) begin
      wake.st = radio_ctl_pkg::ST_CONFIG;
      wake = arm(wake, 32'(CFG_PROMPT_CYC), radio_ctl_pkg::ACT_PROMPT);
    end
  endfunction

  always_comb begin
    logic expire;
    expire = 1'b0;
    s_d = s_q;
    s_d.prompt = 1'b0;
    s_d.char_send = 1'b0;
    s_d.tx_start = 1'b0;
    s_d.rssi = 1'b0;
    s_d.nvm_wr = 1'b0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.rxd_prev = rxd_s;
    if (s_q.busy) begin
      s_d.timer = s_q.timer - 32'h1;
      if (s_q.timer == 32'h1) begin
        s_d.busy = 1'b0;
        expire = 1'b1;
      end
    end
    if (s_q.cts_tmr != 12'h0) begin
      s_d.cts_tmr = s_q.cts_tmr - 12'h1;
      if (s_q.cts_tmr == 12'h1) begin
        s_d.cts_n = 1'b0; // [RL14]
      end
    end
    // stored settings come back once after every power-up reset
    if (!s_q.loaded) begin
      s_d.sel = NVM_SLEEP_SEL; // [RL9]
      s_d.loaded = 1'b1;
    end
    // one wait state: pready rises the cycle after the access phase
    if (PSEL && PENABLE && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0;
      case (PADDR)
        `ADDR_CTRL: begin
          s_d.prdata = {24'h0, s_q.sel};
        end
        `ADDR_STATUS: begin
          s_d.prdata = {s_q.rx_cnt, s_q.tx_cnt, 6'h0, s_q.cts_n,
                        s_q.asleep, 5'h0, s_q.st};
        end
        default: begin
          s_d.pslverr = 1'b1;
        end
      endcase
    end
    if (PSEL && PENABLE && s_q.pready && PWRITE &&
        PADDR == `ADDR_CTRL) begin
      s_d.sel = PWDATA[7:0];
    end
    case (s_q.st)
      radio_ctl_pkg::ST_IDLE: begin
        if (s_q.sel == `SEL_PIN && !doze_s) begin
          s_d = go_sleep(s_d); // [RL5]
        end else if (!setup_s) begin // [RL23]
          s_d.st = radio_ctl_pkg::ST_CONFIG; // [RL10]
          s_d = arm(s_d, 32'(CFG_PROMPT_CYC),
                    radio_ctl_pkg::ACT_PROMPT); // [RL17]
        end else if (HOST_BYTE) begin
          s_d.st = radio_ctl_pkg::ST_HOST_RX;
          s_d.tx_cnt = 8'h1;
          s_d.post = 1'b0;
        end else if (AIR_PREAMBLE) begin
          s_d.st = radio_ctl_pkg::ST_AIR_RX;
          s_d.rx_cnt = 8'h0;
          s_d.post = 1'b0;
        end
      end
      radio_ctl_pkg::ST_HOST_RX: begin
        if (!s_q.post) begin
          // a full buffer drops further bytes rather than overwrite
          if (HOST_BYTE && s_q.tx_cnt < 8'(BUF_BYTES)) begin
            s_d.tx_cnt = s_q.tx_cnt + 8'h1; // [RL1]
          end
          if (HOST_END) begin
            s_d.post = 1'b1;
            s_d.cts_n = 1'b1;
            s_d.cts_tmr = 12'(RXD_CTS_CYC); // [RL14]
            s_d = arm(s_d, 32'(RXD_TX_CYC),
                      radio_ctl_pkg::ACT_PROMPT); // [RL15]
          end
        end else if (expire) begin
          s_d.st = radio_ctl_pkg::ST_AIR_TX;
          s_d.post = 1'b0;
          s_d.tx_start = 1'b1; // [RL1]
          s_d = arm(s_d, air_cycles(s_q.tx_cnt),
                    radio_ctl_pkg::ACT_PROMPT); // [RL20]
        end
      end
      radio_ctl_pkg::ST_AIR_TX: begin
        if (expire && !s_q.post) begin
          s_d.post = 1'b1;
          s_d = arm(s_d, 32'(TX_IDLE_CYC),
                    radio_ctl_pkg::ACT_PROMPT); // [RL16]
        end else if (expire) begin
          s_d.st = radio_ctl_pkg::ST_IDLE;
          s_d.tx_cnt = 8'h0;
          s_d.post = 1'b0;
        end
      end
      radio_ctl_pkg::ST_AIR_RX: begin
        if (!s_q.post) begin
          if (AIR_BYTE && s_q.rx_cnt < 8'(BUF_BYTES)) begin
            s_d.rx_cnt = s_q.rx_cnt + 8'h1; // [RL1]
          end
          if (AIR_END) begin
            s_d.post = 1'b1;
            s_d = arm(s_d, 32'(RX_TXD_CYC),
                      radio_ctl_pkg::ACT_PROMPT); // [RL11]
          end
        end else if (expire) begin
          s_d.st = radio_ctl_pkg::ST_HOST_TX;
          if (s_q.rx_cnt == 8'h0) begin
            s_d = arm(s_d, 32'(TXD_IDLE_CYC), radio_ctl_pkg::ACT_PROMPT);
          end else begin
            s_d.post = 1'b0;
            s_d.char_send = 1'b1; // [RL11]
            s_d.rx_cnt = s_q.rx_cnt - 8'h1;
            s_d = arm(s_d, 32'(CHAR_CYC), radio_ctl_pkg::ACT_PROMPT);
          end
        end
      end
      radio_ctl_pkg::ST_HOST_TX: begin
        if (expire && !s_q.post) begin
          if (s_q.rx_cnt != 8'h0) begin
            s_d.char_send = 1'b1;
            s_d.rx_cnt = s_q.rx_cnt - 8'h1;
            s_d = arm(s_d, 32'(CHAR_CYC),
                      radio_ctl_pkg::ACT_PROMPT); // [RL12] [RL24]
          end else begin
            s_d.post = 1'b1;
            s_d = arm(s_d, 32'(TXD_IDLE_CYC),
                      radio_ctl_pkg::ACT_PROMPT); // [RL13]
          end
        end else if (expire) begin
          s_d.st = radio_ctl_pkg::ST_IDLE;
          s_d.post = 1'b0;
        end
      end
      radio_ctl_pkg::ST_CONFIG: begin
        if (expire) begin
          s_d.prompt = 1'b1;
          s_d.rssi = (s_q.act == radio_ctl_pkg::ACT_RSSI); // [RL21]
        end else if (!s_q.busy) begin
          if (DOZE_CMD && !setup_s && s_q.sel == `SEL_CMD) begin
            s_d = go_sleep(s_d); // [RL2]
          end else if (MEM_WRITE_CMD) begin
            s_d.st = radio_ctl_pkg::ST_MEM_CONFIG; // [RL10]
          end else if (CHAN_CMD) begin
            s_d = arm(s_d, 32'(CHAN_CYC),
                      radio_ctl_pkg::ACT_PROMPT); // [RL18]
          end else if (RSSI_CMD) begin
            s_d = arm(s_d, 32'(RSSI_CYC),
                      radio_ctl_pkg::ACT_RSSI); // [RL21]
          end else if (OTHER_CMD) begin
            s_d.prompt = 1'b1; // [RL18]
          end else if (EXIT_CMD && setup_s) begin
            s_d.st = radio_ctl_pkg::ST_IDLE;
          end
        end
      end
      radio_ctl_pkg::ST_MEM_CONFIG: begin
        if (MEM_TERM && !s_q.busy) begin
          s_d = arm(s_d, 32'(MEM_CFG_CYC),
                    radio_ctl_pkg::ACT_NVM); // [RL19]
        end else if (expire) begin
          s_d.nvm_wr = 1'b1; // [RL19]
          s_d.prompt = 1'b1;
          s_d.st = radio_ctl_pkg::ST_CONFIG;
        end
      end
      radio_ctl_pkg::ST_SLEEP: begin
        // settings and counters are untouched while asleep
        s_d.asleep = 1'b1; // [RL9]
        if (s_q.sel == `SEL_PIN) begin
          if (doze_s) begin
            s_d = wake(s_d, !setup_s); // [RL5] [RL6] [RL7]
          end
        end else if (setup_s) begin
          s_d = wake(s_d, 1'b0); // [RL3]
        end else if (rxd_s != s_q.rxd_prev) begin
          s_d.asleep = 1'b0; // [RL4]
        end
      end
      default: begin
        s_d.st = radio_ctl_pkg::ST_IDLE;
      end
    endcase
    s_d.search = (s_d.st == radio_ctl_pkg::ST_IDLE); // [RL22]
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      s_q <= '0;
      s_q.sel <= `SEL_RESET;
      s_q.search <= 1'b1;
      s_q.pull_en <= 1'b1;
      s_q.rxd_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign PRDATA = s_q.prdata;
  assign PREADY = s_q.pready;
  assign PSLVERR = s_q.pslverr;
  assign HOST_CTS_N = s_q.cts_n;
  assign PROMPT_SEND = s_q.prompt;
  assign HOST_CHAR_SEND = s_q.char_send;
  assign AIR_TX_START = s_q.tx_start;
  assign RSSI_SEND = s_q.rssi;
  assign PREAMBLE_SEARCH = s_q.search;
  assign ASLEEP = s_q.asleep;
  assign SETUP_PULLUP_EN = s_q.pull_en;
  assign DOZE_PULLUP_EN = s_q.pull_en;
  assign NVM_WRITE = s_q.nvm_wr;
  assign NVM_WDATA = s_q.sel;
  assign OP_STATE = s_q.st;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_B);

  sequence s_host_done;
    s_q.st == radio_ctl_pkg::ST_HOST_RX && !s_q.post && HOST_END;
  endsequence

  property p_cts_hold;
    s_host_done |=> HOST_CTS_N && s_q.cts_tmr == 12'(RXD_CTS_CYC);
  endproperty
  a_cts_hold: assert property (p_cts_hold) // [RL14]
    else $error("clear-to-send not held for its delay");

  property p_rf_wait;
    s_host_done |=> s_q.busy && s_q.timer == 32'(RXD_TX_CYC);
  endproperty
  a_rf_wait: assert property (p_rf_wait) // [RL15]
    else $error("air start delay not loaded");

  property p_air_time;
    AIR_TX_START |-> s_q.st == radio_ctl_pkg::ST_AIR_TX &&
      s_q.timer == air_cycles(s_q.tx_cnt);
  endproperty
  a_air_time: assert property (p_air_time) // [RL20]
    else $error("air time does not match byte count");

  property p_char_gap;
    HOST_CHAR_SEND |-> s_q.timer == 32'(CHAR_CYC) ##1
      (!HOST_CHAR_SEND)[*8];
  endproperty
  a_char_gap: assert property (p_char_gap) // [RL12]
    else $error("host character period wrong");

  property p_sleep_pull;
    ASLEEP |-> !SETUP_PULLUP_EN && !DOZE_PULLUP_EN;
  endproperty
  a_sleep_pull: assert property (p_sleep_pull) // [RL8]
    else $error("pull-ups on while asleep");

  property p_pin_hold;
    s_q.st == radio_ctl_pkg::ST_SLEEP && s_q.sel == `SEL_PIN &&
      !doze_s |=> s_q.st == radio_ctl_pkg::ST_SLEEP && ASLEEP;
  endproperty
  a_pin_hold: assert property (p_pin_hold) // [RL6]
    else $error("pin sleep left without doze pin");

  property p_pin_enter;
    s_q.st == radio_ctl_pkg::ST_IDLE && s_q.sel == `SEL_PIN &&
      !doze_s |=> s_q.st == radio_ctl_pkg::ST_SLEEP;
  endproperty
  a_pin_enter: assert property (p_pin_enter) // [RL5]
    else $error("doze pin low did not enter sleep");

  property p_cmd_wake;
    s_q.st == radio_ctl_pkg::ST_SLEEP && s_q.sel == `SEL_CMD &&
      setup_s |=> s_q.st == radio_ctl_pkg::ST_IDLE ##1 !ASLEEP;
  endproperty
  a_cmd_wake: assert property (p_cmd_wake) // [RL3]
    else $error("setup release did not wake");

  property p_cfg_prompt;
    s_q.st == radio_ctl_pkg::ST_IDLE && !setup_s &&
      s_q.sel != `SEL_PIN |=> s_q.st == radio_ctl_pkg::ST_CONFIG &&
      s_q.timer == 32'(CFG_PROMPT_CYC);
  endproperty
  a_cfg_prompt: assert property (p_cfg_prompt) // [RL17]
    else $error("config entry prompt delay wrong");

  property p_mem_done;
    NVM_WRITE |-> PROMPT_SEND && s_q.st == radio_ctl_pkg::ST_CONFIG &&
      $past(s_q.st) == radio_ctl_pkg::ST_MEM_CONFIG;
  endproperty
  a_mem_done: assert property (p_mem_done) // [RL19]
    else $error("memory write without prompt");

endmodule

// [verification/host_pins.sv]
// Purpose: host side pin model for the radio controller
// Assumes: bench requests levels, model drives every pin actively
// Notes: no pull-up is relied on, pins are never left floating
`timescale 1ns/100ps
module host_pins (
  input wire logic clk,
  input wire logic setup_req,
  input wire logic doze_req,
  input wire logic rxd_req,
  output logic setup_n,
  output logic doze,
  output logic rxd
);
  initial begin
    setup_n = 1'b1;
    doze = 1'b1;
    rxd = 1'b1;
  end
  always @(posedge clk) begin
    setup_n <= setup_req;
    // doze only rises once setup is high, else wake lands in config
    if (!(doze_req && !setup_n)) begin
      doze <= doze_req;
    end
    rxd <= rxd_req; // idle high between frames
  end
endmodule

// [verification/test_radio_state_ctl.sv]
// Purpose: self-checking bench for the radio state controller
// Assumes: shortened latency parameters, fixed 2500 cycle cts delay
// Notes: delays allow a few cycles slack for pin synchronisers
`timescale 1ns/100ps
module test_radio_state_ctl;
  localparam int RXT = 20;
  localparam int CHR = 30;
  localparam int TXI = 40;
  localparam int RTX = 50;
  localparam int TID = 60;
  localparam int CFP = 70;
  localparam int CHN = 80;
  localparam int MEM = 90;
  localparam int AIR = 20;
  localparam int RSI = 100;
  typedef struct {int ev; int sg; int dly;} row_s;
  row_s rows[3] = '{'{8, 0, CHN}, '{10, 0, 1}, '{9, 1, RSI}};
  logic CORE_CLK = 1'b0;
  logic RST_B = 1'b0;
  logic psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, PRDATA;
  logic err, PREADY, PSLVERR, rxd, setup_n, doze;
  logic setup_r, doze_r, rxd_r;
  logic [11:0] ev;
  logic [7:0] sel_nvm, NVM_WDATA;
  logic HOST_CTS_N, PROMPT_SEND, HOST_CHAR_SEND, AIR_TX_START, RSSI_SEND;
  logic PREAMBLE_SEARCH, ASLEEP, SETUP_PULLUP_EN, DOZE_PULLUP_EN, NVM_WRITE;
  logic [2:0] OP_STATE;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  int t0, t1, t2, t3, lows, bad;
  always #4 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) cyc <= cyc + 1;
  host_pins hp (.clk(CORE_CLK), .setup_req(setup_r), .doze_req(doze_r),
    .rxd_req(rxd_r), .setup_n(setup_n), .doze(doze), .rxd(rxd));
  radio_state_ctl #(.RX_TXD_CYC(RXT), .CHAR_CYC(CHR), .TXD_IDLE_CYC(TXI),
    .RXD_TX_CYC(RTX), .TX_IDLE_CYC(TID), .CFG_PROMPT_CYC(CFP),
    .CHAN_CYC(CHN), .MEM_CFG_CYC(MEM), .AIR_BYTE_CYC(AIR),
    .RSSI_CYC(RSI), .BUF_BYTES(128)) uut (
    .CORE_CLK(CORE_CLK), .RST_B(RST_B), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .RXD_PIN(rxd),
    .SETUP_MODE_N(setup_n), .FLOW_REQUEST_DOZE(doze),
    .HOST_BYTE(ev[0]), .HOST_END(ev[1]), .AIR_PREAMBLE(ev[2]),
    .AIR_BYTE(ev[3]), .AIR_END(ev[4]), .DOZE_CMD(ev[5]),
    .MEM_WRITE_CMD(ev[6]), .MEM_TERM(ev[7]), .CHAN_CMD(ev[8]),
    .RSSI_CMD(ev[9]), .OTHER_CMD(ev[10]), .EXIT_CMD(ev[11]),
    .NVM_SLEEP_SEL(sel_nvm), .HOST_CTS_N(HOST_CTS_N),
    .PROMPT_SEND(PROMPT_SEND), .HOST_CHAR_SEND(HOST_CHAR_SEND),
    .AIR_TX_START(AIR_TX_START), .RSSI_SEND(RSSI_SEND),
    .PREAMBLE_SEARCH(PREAMBLE_SEARCH), .ASLEEP(ASLEEP),
    .SETUP_PULLUP_EN(SETUP_PULLUP_EN), .DOZE_PULLUP_EN(DOZE_PULLUP_EN),
    .NVM_WRITE(NVM_WRITE), .NVM_WDATA(NVM_WDATA), .OP_STATE(OP_STATE));
  task end_sim;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rng(input int d, input int lo, input int hi);
    compares++;
    if (d < lo || d > hi) begin
      errors++;
      $display("Error at %0t: delay %h expected %h..%h", $time, d, lo, hi);
    end
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return PROMPT_SEND;
      1: return RSSI_SEND;
      2: return NVM_WRITE;
      3: return AIR_TX_START;
      4: return HOST_CHAR_SEND;
      5: return ASLEEP;
      6: return HOST_CTS_N;
      7: return OP_STATE == 3'h0;
      default: return !HOST_CTS_N;
    endcase
  endfunction
  // a wait that runs out is a mismatch and ends the run
  task wait_sig(input int k, output int at);
    int n;
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (sig(k) !== 1'b1 && n < 4000);
    if (n >= 4000) begin
      $display("Error at %0t: wait %h timed out %h", $time, k, n);
      errors++;
      end_sim();
    end
    at = cyc;
  endtask
  task pulse(input int k);
    @(posedge CORE_CLK);
    ev[k] <= 1'b1;
    @(posedge CORE_CLK);
    ev[k] <= 1'b0;
    t0 = cyc;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge CORE_CLK);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge CORE_CLK);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) begin
      $display("Error at %0t: bus wait timed out %h", $time, n);
      errors++;
      end_sim();
    end
    rd = PRDATA;
    err = PSLVERR;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    #800000;
    $display("Error at %0t: run limit reached %h", $time, cyc);
    errors++;
    end_sim();
  end
  initial begin
    {psel, penable, pwrite, setup_r, doze_r, rxd_r} = 6'h07;
    paddr = 12'h000;
    pwdata = 32'h0;
    ev = 12'h000;
    sel_nvm = 8'h00;
    repeat (3) @(posedge CORE_CLK);
    chk({SETUP_PULLUP_EN, DOZE_PULLUP_EN, ASLEEP, OP_STATE}, 6'h30);
    chk(PREAMBLE_SEARCH, 1'b1);
    RST_B <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    $display("done: reset");
    for (int i = 0; i < 3; i++) pulse(0);
    chk(OP_STATE, 3'h1);
    pulse(1);
    wait_sig(6, t1);
    rng(t1 - t0, 1, 2);
    wait_sig(3, t2);
    rng(t2 - t0, RTX - 1, RTX + 2);
    wait_sig(7, t3);
    rng(t3 - t2, 14 * AIR + TID - 1, 14 * AIR + TID + 3);
    wait_sig(8, t3);
    rng(t3 - t0, 2500, 2504);
    $display("done: host to air");
    pulse(2);
    // the state register updates on the edge that took the pulse
    @(posedge CORE_CLK);
    chk(OP_STATE, 3'h3);
    pulse(3);
    pulse(3);
    pulse(4);
    wait_sig(4, t1);
    rng(t1 - t0, RXT - 1, RXT + 2);
    wait_sig(4, t2);
    rng(t2 - t1, CHR - 1, CHR + 2);
    wait_sig(7, t3);
    rng(t3 - t2, CHR + TXI - 1, CHR + TXI + 3);
    chk(PREAMBLE_SEARCH, 1'b1);
    $display("done: air to host");
    @(posedge CORE_CLK);
    setup_r <= 1'b0;
    t0 = cyc;
    wait_sig(0, t1);
    rng(t1 - t0, CFP - 1, CFP + 6);
    chk(OP_STATE, 3'h5);
    setup_r <= 1'b1;
    foreach (rows[i]) begin
      pulse(rows[i].ev);
      wait_sig(rows[i].sg, t1);
      rng(t1 - t0, rows[i].dly - 1, rows[i].dly + 3);
      chk(PROMPT_SEND, 1'b1);
    end
    apb(1'b1, 12'h000, 32'h2);
    pulse(6);
    repeat (3) @(posedge CORE_CLK);
    chk(OP_STATE, 3'h6);
    pulse(7);
    wait_sig(2, t1);
    rng(t1 - t0, MEM - 1, MEM + 3);
    chk({PROMPT_SEND, NVM_WDATA}, 9'h102);
    repeat (3) @(posedge CORE_CLK);
    chk(OP_STATE, 3'h5);
    pulse(11);
    repeat (3) @(posedge CORE_CLK);
    chk(OP_STATE, 3'h0);
    $display("done: config");
    doze_r <= 1'b0;
    wait_sig(5, t1);
    chk({SETUP_PULLUP_EN, DOZE_PULLUP_EN, OP_STATE}, 5'h07);
    rxd_r <= 1'b0;
    setup_r <= 1'b0;
    repeat (8) @(posedge CORE_CLK);
    rxd_r <= 1'b1;
    setup_r <= 1'b1;
    repeat (8) @(posedge CORE_CLK);
    chk({ASLEEP, OP_STATE}, 4'hf);
    doze_r <= 1'b1;
    wait_sig(7, t1);
    chk(ASLEEP, 1'b0);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h2);
    $display("done: pin sleep");
    apb(1'b1, 12'h000, 32'h0);
    setup_r <= 1'b0;
    wait_sig(0, t1);
    pulse(5);
    repeat (3) @(posedge CORE_CLK);
    chk(OP_STATE, 3'h7);
    lows = 0;
    bad = 0;
    for (int i = 0; i < 20; i++) begin
      @(posedge CORE_CLK);
      rxd_r <= (i >= 10);
      lows += (ASLEEP !== 1'b1);
      bad += (OP_STATE !== 3'h7);
    end
    chk(lows, 2);
    chk(bad, 0);
    setup_r <= 1'b1;
    wait_sig(7, t1);
    chk(ASLEEP, 1'b0);
    $display("done: command sleep");
    apb(1'b0, 12'h100, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    $display("done: unmapped");
    // stored select differs from the reset value, so the reload shows
    sel_nvm <= 8'h02;
    RST_B <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h2);
    $display("done: power-up restore");
    end_sim();
  end
endmodule
